/* common/acs_pkg.sv */
// Constants for the converter conversion sequencer.
// Assumes a 32-bit AHB-Lite register bus and one 250 MHz core clock.
// Functional notes
// - Power-on reset does not touch the result pair; contents unknown.
// - Each ten-bit conversion takes twelve bit periods.
// - Clock select picks 2 to 64 core periods, or the RC clock.
// - Port reads return low on every pin set as analog.
// - A selected pin driven as output converts its own driven level.
// - Sequencing ignores channel and direction bits; they pick the level.
// - Clearing start mid-conversion aborts; result pair is left unchanged.
// - After an abort, wait two bit periods, then acquire again.
// - Compare-two trigger in mode 1011 starts a conversion, clears timer.
// - With the converter off, the trigger starts nothing but clears timer.
// - On completion: load result pair, clear start bit, set done flag.
// - Any reset turns the converter off and aborts a conversion.

package acs_pkg;

    // ========================================================
    // Register map
    localparam logic [7:0] REG_CTRL0 = 8'h00;
    localparam logic [7:0] REG_CTRL2 = 8'h04;
    localparam logic [7:0] REG_RES_HI = 8'h08;
    localparam logic [7:0] REG_RES_LO = 8'h0c;
    localparam logic [7:0] REG_IRQ = 8'h10;
    localparam logic [7:0] REG_CMP2 = 8'h14;
    localparam logic [7:0] REG_ANALOG = 8'h18;
    localparam logic [7:0] REG_PORT = 8'h1c;

    // ========================================================
    // Field positions
    localparam int CTRL0_ON_BIT = 0;
    localparam int CTRL0_GO_BIT = 1;
    localparam int CTRL0_CHS_LSB = 2;
    localparam int CTRL0_ACQ_BIT = 6;
    localparam int CTRL2_SEL_LSB = 0;
    localparam int CTRL2_FMT_BIT = 7;
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT = 1;
    localparam int CMP2_MODE_LSB = 0;
    localparam int ANALOG_LSB = 0;

    // ========================================================
    // Widths and reset values
    localparam int RES_BITS = 10;
    localparam int PIN_COUNT = 16;
    localparam logic [3:0] CHS_RST = 4'h0;
    localparam logic [2:0] SEL_RST = 3'h0;
    localparam logic [3:0] CMP2_RST = 4'h0;
    localparam logic [15:0] ANALOG_RST = 16'h0000;
    localparam logic [9:0] SAR_RST = 10'h000;
    localparam logic [9:0] SAR_FIRST = 10'h200;

    // ========================================================
    // Timing and encodings
    localparam logic [3:0] CONV_TADS = 4'hc;
    localparam logic [3:0] RESOLVE_TADS = 4'ha;
    localparam logic [3:0] MSB_IDX = 4'h9;
    localparam logic [3:0] HOLD_TADS = 4'h2;
    localparam logic [3:0] TRIG_MODE = 4'hb;
    localparam logic [1:0] SEL_RC = 2'h3;
    localparam logic [6:0] DIV_BASE = 7'h02;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_CONV = 3'b010,
        ST_HOLD = 3'b100
    } acs_state_t;

endpackage : acs_pkg

/* hw/acs_pin_sync.sv */
// Three-stage synchroniser for levels from outside the clock domain.
// Assumes hclk; output follows once stages two and three agree.
`timescale 1ns/1ns
`default_nettype none

module acs_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    // ========================================================
    // Per-bit synchroniser
    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_bit
            logic s1_q;
            logic s2_q;
            logic s3_q;
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    s1_q <= 1'b0;
                    s2_q <= 1'b0;
                    s3_q <= 1'b0;
                    sync_out[i] <= 1'b0;
                end else begin
                    s1_q <= async_in[i];
                    s2_q <= s1_q;
                    s3_q <= s2_q;
                    if (s2_q == s3_q) begin
                        sync_out[i] <= s3_q;
                    end
                end
            end
        end
    endgenerate

endmodule : acs_pin_sync

`default_nettype wire

/* hw/acs_bit_clock.sv */
// Bit period tick generator for the conversion sequencer.
// Assumes hclk is the oscillator; RC level arrives already synchronised.
`timescale 1ns/1ns
`default_nettype none

module acs_bit_clock
    import acs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic [2:0] clk_sel,
    input wire logic clear,
    input wire logic rc_level,
    output logic tad_tick
);

    logic [5:0] cnt_q;
    logic rc_prev_q;
    logic [2:0] div_idx;
    logic [5:0] div_last;
    logic use_rc;

    // ========================================================
    // Divider selection
    assign div_idx = {clk_sel[1:0], clk_sel[2]};
    assign div_last = 6'((DIV_BASE << div_idx) - 7'h01);
    assign use_rc = (clk_sel[1:0] == SEL_RC);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 6'h00;
        end else if (clear || tad_tick) begin
            cnt_q <= 6'h00;
        end else if (!use_rc) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rc_prev_q <= 1'b0;
        end else begin
            rc_prev_q <= rc_level;
        end
    end

    always_comb begin
        if (clear) begin
            tad_tick = 1'b0;
        end else if (use_rc) begin
            tad_tick = rc_level && !rc_prev_q;
        end else begin
            tad_tick = (cnt_q == div_last);
        end
    end

endmodule : acs_bit_clock

`default_nettype wire

/* hw/acs_sequencer.sv */
// Converter conversion sequencer with AHB-Lite register slave.
// Assumes single-word AHB-Lite transfers, analog comparator outside.
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer
    import acs_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic analog_above,
    input wire logic [15:0] pin_level,
    input wire logic [15:0] pin_direction,
    input wire logic [15:0] pin_drive_level,
    input wire logic rc_osc,
    input wire logic special_event_trigger,
    output logic timer_clear,
    output logic [9:0] sar_trial,
    output logic converting,
    output logic acquiring,
    output logic converter_on,
    output logic [3:0] channel_select,
    output logic conversion_done_flag,
    output logic conversion_irq_enable
);

    // ========================================================
    // Declarations
    acs_state_t state_q;
    acs_state_t state_d;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] hrdata_q;
    logic [31:0] rd_data;
    logic on_q;
    logic go_q;
    logic go_d;
    logic [3:0] chs_q;
    logic fmt_q;
    logic [2:0] sel_q;
    logic flag_q;
    logic irq_en_q;
    logic [3:0] cmp2_q;
    logic [15:0] analog_q;
    logic [7:0] res_hi_q;
    logic [7:0] res_lo_q;
    logic [9:0] trial_q;
    logic [3:0] tad_cnt_q;
    logic timer_clear_q;
    logic [15:0] pin_sync;
    logic rc_sync;
    logic tad_tick;
    logic addr_ok;
    logic wr_ctrl0;
    logic wr_ctrl2;
    logic wr_hi;
    logic wr_lo;
    logic wr_irq;
    logic wr_cmp2;
    logic wr_analog;
    logic st_idle;
    logic st_conv;
    logic st_hold;
    logic start_evt;
    logic abort;
    logic done_evt;
    logic hold_end;
    logic resolve;
    logic keep;
    logic trig_start;
    logic [3:0] bit_idx;

    // ========================================================
    // Submodules
    acs_pin_sync #(.WIDTH(PIN_COUNT)) u_pin_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(pin_level),
        .sync_out(pin_sync)
    );

    acs_pin_sync #(.WIDTH(1)) u_rc_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .async_in(rc_osc),
        .sync_out(rc_sync)
    );

    acs_bit_clock u_bit_clock (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_sel(sel_q),
        .clear(start_evt || abort),
        .rc_level(rc_sync),
        .tad_tick(tad_tick)
    );

    // ========================================================
    // AHB-Lite slave
    assign addr_ok = hsel && htrans[1] && hready;
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_ok && hwrite;
            if (addr_ok) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    assign wr_ctrl0 = wr_pend_q && (wr_addr_q == REG_CTRL0);
    assign wr_ctrl2 = wr_pend_q && (wr_addr_q == REG_CTRL2);
    assign wr_hi = wr_pend_q && (wr_addr_q == REG_RES_HI);
    assign wr_lo = wr_pend_q && (wr_addr_q == REG_RES_LO);
    assign wr_irq = wr_pend_q && (wr_addr_q == REG_IRQ);
    assign wr_cmp2 = wr_pend_q && (wr_addr_q == REG_CMP2);
    assign wr_analog = wr_pend_q && (wr_addr_q == REG_ANALOG);

    always_comb begin
        rd_data = 32'h0000_0000;
        case (haddr[7:0])
            REG_CTRL0: begin
                rd_data[CTRL0_ON_BIT] = on_q;
                rd_data[CTRL0_GO_BIT] = go_q;
                rd_data[CTRL0_CHS_LSB +: 4] = chs_q;
                rd_data[CTRL0_ACQ_BIT] = acquiring;
            end
            REG_CTRL2: begin
                rd_data[CTRL2_SEL_LSB +: 3] = sel_q;
                rd_data[CTRL2_FMT_BIT] = fmt_q;
            end
            REG_RES_HI: rd_data[7:0] = res_hi_q;
            REG_RES_LO: rd_data[7:0] = res_lo_q;
            REG_IRQ: begin
                rd_data[IRQ_FLAG_BIT] = flag_q;
                rd_data[IRQ_EN_BIT] = irq_en_q;
            end
            REG_CMP2: rd_data[CMP2_MODE_LSB +: 4] = cmp2_q;
            REG_ANALOG: rd_data[ANALOG_LSB +: 16] = analog_q;
            REG_PORT: rd_data[15:0] = pin_sync & ~analog_q;
            default: rd_data = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_q <= 32'h0000_0000;
        end else if (addr_ok && !hwrite) begin
            hrdata_q <= rd_data;
        end
    end

    // ========================================================
    // Configuration registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            on_q <= 1'b0;
            chs_q <= CHS_RST;
            sel_q <= SEL_RST;
            fmt_q <= 1'b0;
            irq_en_q <= 1'b0;
            cmp2_q <= CMP2_RST;
            analog_q <= ANALOG_RST;
        end else begin
            if (wr_ctrl0) begin
                on_q <= hwdata[CTRL0_ON_BIT];
                chs_q <= hwdata[CTRL0_CHS_LSB +: 4];
            end
            if (wr_ctrl2) begin
                sel_q <= hwdata[CTRL2_SEL_LSB +: 3];
                fmt_q <= hwdata[CTRL2_FMT_BIT];
            end
            if (wr_irq) begin
                irq_en_q <= hwdata[IRQ_EN_BIT];
            end
            if (wr_cmp2) begin
                cmp2_q <= hwdata[CMP2_MODE_LSB +: 4];
            end
            if (wr_analog) begin
                analog_q <= hwdata[ANALOG_LSB +: 16];
            end
        end
    end

    // ========================================================
    // Start bit, trigger and done flag
    assign trig_start = special_event_trigger && on_q
        && (cmp2_q == TRIG_MODE);

    always_comb begin
        go_d = go_q;
        if (wr_ctrl0) begin
            go_d = hwdata[CTRL0_GO_BIT];
        end
        if (done_evt) begin
            go_d = 1'b0;
        end
        if (trig_start) begin
            go_d = 1'b1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            go_q <= 1'b0;
        end else begin
            go_q <= go_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            flag_q <= 1'b0;
        end else if (done_evt) begin
            flag_q <= 1'b1;
        end else if (wr_irq) begin
            flag_q <= hwdata[IRQ_FLAG_BIT];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            timer_clear_q <= 1'b0;
        end else begin
            timer_clear_q <= special_event_trigger;
        end
    end

    // ========================================================
    // Sequencer
    assign st_idle = (state_q == ST_IDLE);
    assign st_conv = (state_q == ST_CONV);
    assign st_hold = (state_q == ST_HOLD);
    assign start_evt = st_idle && go_q && on_q;
    assign abort = st_conv && (!go_q || !on_q);
    assign done_evt = st_conv && !abort && tad_tick
        && (tad_cnt_q == CONV_TADS - 4'h1);
    assign hold_end = st_hold && tad_tick
        && (tad_cnt_q == HOLD_TADS - 4'h1);
    assign resolve = st_conv && !abort && tad_tick
        && (tad_cnt_q < RESOLVE_TADS);
    assign bit_idx = MSB_IDX - tad_cnt_q;

    // Direction bits pick the level only, never the timing
    assign keep = pin_direction[chs_q] ? analog_above
        : pin_drive_level[chs_q];

    always_comb begin
        state_d = state_q;
        unique case (state_q)
            ST_IDLE: begin
                if (start_evt) begin
                    state_d = ST_CONV;
                end
            end
            ST_CONV: begin
                if (abort) begin
                    state_d = ST_HOLD;
                end else if (done_evt) begin
                    state_d = ST_IDLE;
                end
            end
            ST_HOLD: begin
                if (hold_end) begin
                    state_d = ST_IDLE;
                end
            end
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_q <= ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            tad_cnt_q <= 4'h0;
        end else if (start_evt || abort) begin
            tad_cnt_q <= 4'h0;
        end else if (tad_tick && (st_conv || st_hold)) begin
            tad_cnt_q <= tad_cnt_q + 4'h1;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            trial_q <= SAR_RST;
        end else if (start_evt) begin
            trial_q <= SAR_FIRST;
        end else if (resolve) begin
            for (int i = 0; i < RES_BITS; i++) begin
                if (i == int'(bit_idx)) begin
                    trial_q[i] <= keep;
                end else if (i + 1 == int'(bit_idx)) begin
                    trial_q[i] <= 1'b1;
                end
            end
        end
    end

    // Result pair has no reset; a finished conversion or a bus write loads it
    always_ff @(posedge hclk) begin
        if (done_evt) begin
            res_hi_q <= fmt_q ? {6'h00, trial_q[9:8]} : trial_q[9:2];
            res_lo_q <= fmt_q ? trial_q[7:0] : {trial_q[1:0], 6'h00};
        end else begin
            if (wr_hi) begin
                res_hi_q <= hwdata[7:0];
            end
            if (wr_lo) begin
                res_lo_q <= hwdata[7:0];
            end
        end
    end

    // ========================================================
    // Outputs
    assign timer_clear = timer_clear_q;
    assign sar_trial = trial_q;
    assign converting = st_conv;
    assign acquiring = st_idle && on_q;
    assign converter_on = on_q;
    assign channel_select = chs_q;
    assign conversion_done_flag = flag_q;
    assign conversion_irq_enable = irq_en_q;

    // ========================================================
    // Checks
    logic [3:0] conv_ticks_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            conv_ticks_q <= 4'h0;
        end else if (!st_conv) begin
            conv_ticks_q <= 4'h0;
        end else if (tad_tick) begin
            conv_ticks_q <= conv_ticks_q + 4'h1;
        end
    end

    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    sequence abort_seq;
        st_conv && !go_q;
    endsequence

    sequence hold_two_seq;
        st_hold ##1 (st_hold || st_idle);
    endsequence

    chk_conv_length: assert property (
        done_evt |-> conv_ticks_q == 4'hb)
        else $error("conversion did not take twelve bit periods");

    chk_done_effects: assert property (
        done_evt && !trig_start |=> flag_q && !go_q && st_idle)
        else $error("completion did not clear start and set flag");

    chk_abort_hold: assert property (
        abort_seq |=> hold_two_seq)
        else $error("abort did not enter the hold wait");

    chk_hold_exit: assert property (
        $fell(st_hold) |-> $past(tad_cnt_q) == 4'h1 && $past(tad_tick))
        else $error("hold wait left before two bit periods");

    chk_abort_no_load: assert property (
        abort |-> !done_evt ##1 !done_evt)
        else $error("aborted conversion loaded a result");

    chk_trig_start: assert property (
        trig_start && !wr_ctrl0 |=> go_q)
        else $error("trigger did not set the start bit");

    chk_trig_timer: assert property (
        special_event_trigger |=> timer_clear)
        else $error("trigger did not clear the timer");

    chk_trig_ignored: assert property (
        special_event_trigger && !on_q && !go_q && !wr_ctrl0 |=> !go_q)
        else $error("trigger started a disabled converter");

    chk_off_abort: assert property (
        !on_q |=> !st_conv)
        else $error("conversion runs while converter is off");

    chk_port_mask: assert property (
        addr_ok && !hwrite && haddr[7:0] == REG_PORT
        |=> (hrdata_q[15:0] & $past(analog_q)) == 16'h0000)
        else $error("analog pin read back high");

    chk_msb_first: assert property (
        start_evt |=> trial_q == SAR_FIRST)
        else $error("conversion did not start at the top bit");

endmodule : acs_sequencer

`default_nettype wire

/* test/acs_sequencer_tb.sv */
// Self-checking bench for the conversion sequencer.
// Assumes acs_pkg and hw/ sources compiled first; one 250 MHz clock.
`timescale 1ns/1ns
`default_nettype none

module acs_sequencer_tb
    import acs_pkg::*;
();
    logic hclk, hresetn, hsel, hwrite, analog_above, rc_osc, set_trig;
    logic [31:0] haddr, hwdata, hrdata, rd_v;
    logic [1:0] htrans;
    logic [15:0] pin_level, pin_dir, pin_drv;
    logic hreadyout, timer_clear, converting, acquiring, converter_on;
    logic hresp, done_flag, irq_en;
    logic [9:0] sar_trial, tgt;
    logic [3:0] channel_select;
    int n_fail, n_tests, cyc, len;
    logic [7:0] ra [6] = '{REG_CTRL2, REG_CMP2, REG_ANALOG, REG_RES_HI,
        REG_RES_LO, 8'h20};
    logic [31:0] rw [6] = '{32'hffffffff, 32'hb, 32'h1234, 32'ha5,
        32'h5a, 32'hffffffff};
    logic [31:0] rx [6] = '{32'h87, 32'hb, 32'h1234, 32'ha5, 32'h5a, 32'h0};
    logic [2:0] sc [6] = '{3'h0, 3'h4, 3'h1, 3'h5, 3'h2, 3'h6};
    int pp [6] = '{2, 4, 8, 16, 32, 64};

    acs_sequencer u_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
        .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .analog_above(analog_above),
        .pin_level(pin_level), .pin_direction(pin_dir),
        .pin_drive_level(pin_drv), .rc_osc(rc_osc),
        .special_event_trigger(set_trig), .timer_clear(timer_clear),
        .sar_trial(sar_trial), .converting(converting),
        .acquiring(acquiring), .converter_on(converter_on),
        .channel_select(channel_select), .conversion_done_flag(done_flag),
        .conversion_irq_enable(irq_en));

    // ========================================================
    // Clock, comparator model, RC clock, timeout
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    always @(posedge hclk) begin
        cyc <= cyc + 1;
        rc_osc <= cyc[8];
        analog_above <= (tgt >= sar_trial);
        if (cyc == 20000) begin
            n_fail = n_fail + 1;
            test_done();
        end
    end

    // ========================================================
    // Tasks
    task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("[ERR] %s exp %h got %h", nm, e, s);
        end
    endtask : chk

    task xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] q);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h0, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        q = hrdata;
        hsel <= 1'b0;
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, rd_v);
    endtask : wr

    task rdc(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, rd_v);
        chk($sformatf("reg %h", a), rd_v, e);
    endtask : rdc

    task meas(output int n);
        int g;
        n = 0;
        g = 0;
        while (converting !== 1'b1 && g < 50) begin
            @(negedge hclk);
            g++;
        end
        while (converting === 1'b1 && n < 8000) begin
            n++;
            @(negedge hclk);
        end
    endtask : meas

    task trig(input logic e);
        @(posedge hclk);
        set_trig <= 1'b1;
        @(posedge hclk);
        set_trig <= 1'b0;
        @(negedge hclk);
        chk("timer_clear", timer_clear, 1'b1);
        repeat (3) @(negedge hclk);
        chk("converting", converting, e);
    endtask : trig

    task test_done();
        if (n_fail == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // ========================================================
    // Main sequence
    initial begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        analog_above = 1'b0;
        rc_osc = 1'b0;
        set_trig = 1'b0;
        pin_level = 16'hffff;
        pin_dir = 16'hffff;
        pin_drv = 16'h0;
        tgt = 10'h3ff;
        n_fail = 0;
        n_tests = 0;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            if (i != 2 && i != 3) begin
                rdc(8'(4 * i), {16'h0, {16{i == 7}}});
            end
        end
        chk("hresp", hresp, 1'b0);
        for (int i = 0; i < 6; i++) begin
            wr(ra[i], rw[i]);
            rdc(ra[i], rx[i]);
        end
        wr(REG_ANALOG, 32'hff);
        rdc(REG_PORT, 32'hff00);
        wr(REG_CTRL0, 32'h1);
        for (int i = 0; i < 6; i++) begin
            wr(REG_CTRL2, {24'h0, 5'h10, sc[i]});
            wr(REG_CTRL0, 32'h3);
            meas(len);
            chk("conv length", len, 12 * pp[i]);
            rdc(REG_CTRL0, 32'h41);
            rdc(REG_RES_HI, 32'h3);
            rdc(REG_RES_LO, 32'hff);
            rdc(REG_IRQ, 32'h1);
            chk("done port", done_flag, 1'b1);
            wr(REG_IRQ, 32'h0);
            repeat (2 * pp[i]) @(posedge hclk);
        end
        // Bit order and left justify
        tgt <= 10'h2a5;
        wr(REG_CTRL2, 32'h0);
        wr(REG_CTRL0, 32'h3);
        meas(len);
        rdc(REG_RES_HI, 32'ha9);
        rdc(REG_RES_LO, 32'h40);
        // Output pin converts its own driven level
        tgt <= 10'h3ff;
        pin_dir <= 16'hfff7;
        wr(REG_CTRL0, 32'hf);
        @(negedge hclk);
        chk("channel", channel_select, 4'h3);
        meas(len);
        chk("conv length", len, 24);
        rdc(REG_RES_HI, 32'h0);
        rdc(REG_RES_LO, 32'h0);
        // Abort mid conversion
        pin_dir <= 16'hffff;
        wr(REG_IRQ, 32'h2);
        wr(REG_CTRL2, 32'h1);
        wr(REG_CTRL0, 32'h3);
        repeat (20) @(posedge hclk);
        wr(REG_CTRL0, 32'h1);
        len = 0;
        for (int g = 0; g < 100 && acquiring !== 1'b1; g++) begin
            @(negedge hclk);
            if (converting !== 1'b1) len++;
        end
        chk("hold wait", len >= 15 && len <= 18, 1'b1);
        rdc(REG_RES_HI, 32'h0);
        rdc(REG_IRQ, 32'h2);
        chk("irq_en port", irq_en, 1'b1);
        // Compare-two trigger
        wr(REG_CMP2, 32'hb);
        trig(1'b1);
        meas(len);
        rdc(REG_IRQ, 32'h3);
        rdc(REG_CTRL0, 32'h41);
        wr(REG_CMP2, 32'h3);
        trig(1'b0);
        wr(REG_CMP2, 32'hb);
        wr(REG_CTRL0, 32'h0);
        trig(1'b0);
        // RC bit clock, then reset in mid conversion
        wr(REG_CTRL2, 32'h3);
        wr(REG_CTRL0, 32'h1);
        wr(REG_CTRL0, 32'h3);
        meas(len);
        chk("rc length", len >= 5600 && len <= 6200, 1'b1);
        wr(REG_CTRL0, 32'h3);
        repeat (10) @(posedge hclk);
        hresetn <= 1'b0;
        @(posedge hclk);
        hresetn <= 1'b1;
        chk("converting", converting, 1'b0);
        chk("converter_on", converter_on, 1'b0);
        rdc(REG_RES_HI, 32'hff);
        test_done();
    end
endmodule : acs_sequencer_tb

`default_nettype wire
